// ===== core/ddr2_params.svh
// Constants of the DDR2 pin-side model: timing, field positions, reset values.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef DDR2_PARAMS_SVH
`define DDR2_PARAMS_SVH

`define DDR2_CLK_PERIOD_NS   4
`define DDR2_BANKS           4
`define DDR2_BANK_BITS       2
`define DDR2_ADDR_BITS       14
`define DDR2_BURST_LEN       4
`define DDR2_COL_BITS        4
`define DDR2_DQ_MAX          16
`define DDR2_DM_MAX          2
`define DDR2_A_ALL_BANKS     10
`define DDR2_EMR_BANK        2'h1
`define DDR2_EMR_RTT0        2
`define DDR2_EMR_RTT1        6
`define DDR2_RTT_RESET       1'b0
`define DDR2_BUF_DEPTH       2

`endif

// ===== core/ddr2_pkg.sv
// Types shared by the DDR2 pin-side model.
// Assumes ddr2_params.svh is compiled alongside.
package ddr2_pkg;

    // Power state as seen from the pins
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_PD_PRE,
        ST_PD_ACT,
        ST_SELF_REF
    } pwr_state_t;

    // Decoded command from the four command pins
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_LOAD_MODE,
        CMD_REFRESH,
        CMD_PRECHARGE,
        CMD_ACTIVATE,
        CMD_WRITE,
        CMD_READ,
        CMD_DESELECT
    } cmd_t;

endpackage : ddr2_pkg

// ===== core/word_mem.sv
// Small byte-lane writable word store with a registered read port.
// Assumes one clock; write and read to the same word in one cycle return old data.
`timescale 1ns/100ps
module word_mem #(
    parameter int WIDTH = 16,
    parameter int LANES = 2,
    parameter int ABITS = 6
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [ABITS-1:0] wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [LANES-1:0] wr_lane_en,
    input  wire logic             rd_en,
    input  wire logic [ABITS-1:0] rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int LW = WIDTH / LANES;

    logic [WIDTH-1:0] store [2**ABITS];

    // Lane-gated write: a masked lane keeps its old content
    always_ff @(posedge clk) begin
        if (wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_en[l]) begin
                    store[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
                end
            end
        end
    end

    // Registered read data
    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule : word_mem

// ===== core/two_entry_buffer.sv
// Two-entry FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/100ps
module two_entry_buffer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] slot_q [2];
    logic             wr_ptr_q;
    logic             rd_ptr_q;
    logic [1:0]       count_q;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data  = slot_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage slots
    always_ff @(posedge clk) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : two_entry_buffer

// ===== core/ddr2_pin_core.sv
// Pin-side behaviour of a DDR2 memory: command capture, power modes,
// write masking, termination control and a burst read path.
// Assumes all pins come from outside the clk domain; clk is much faster than CK.
`timescale 1ns/100ps
`include "ddr2_params.svh"
module ddr2_pin_core #(
    parameter int DQ_WIDTH  = 16,
    parameter int BURST_LEN = `DDR2_BURST_LEN,
    parameter int COL_BITS  = `DDR2_COL_BITS
) (
    input  wire logic                            clk,
    input  wire logic                            srst,
    input  wire logic                            ck,
    input  wire logic                            ck_n,
    input  wire logic                            cke,
    input  wire logic                            cs_n,
    input  wire logic                            ras_n,
    input  wire logic                            cas_n,
    input  wire logic                            we_n,
    input  wire logic [`DDR2_BANK_BITS-1:0]      ba,
    input  wire logic [`DDR2_ADDR_BITS-1:0]      addr,
    input  wire logic                            odt,
    input  wire logic [DQ_WIDTH-1:0]             dq_i,
    output logic      [DQ_WIDTH-1:0]             dq_o,
    output logic                                 dq_oe,
    input  wire logic                            dqs_i,
    output logic                                 dqs_o,
    output logic                                 dqs_oe,
    input  wire logic [`DDR2_DM_MAX-1:0]         dm_i,
    output logic                                 term_en,
    output logic      [DQ_WIDTH-1:0]             term_dq_en,
    output logic                                 clocking_en,
    output ddr2_pkg::pwr_state_t                 pwr_state
);
    import ddr2_pkg::*;

    localparam int LANES = (DQ_WIDTH == 16) ? 2 : 1;
    localparam int ABITS = `DDR2_BANK_BITS + COL_BITS;
    localparam int SYNW  = 9 + `DDR2_BANK_BITS + `DDR2_ADDR_BITS + DQ_WIDTH
                         + `DDR2_DM_MAX;                   // Nine single-bit pins
    localparam logic [3:0] BEATS = 4'(BURST_LEN);

    // Command truth table on the four command pins
    function automatic cmd_t decode_cmd(input logic c, input logic r,
                                        input logic a, input logic w);
        cmd_t res;
        res = CMD_NOP;
        if (c) begin
            res = CMD_DESELECT;
        end else begin
            case ({r, a, w})
                3'h0:    res = CMD_LOAD_MODE;
                3'h1:    res = CMD_REFRESH;
                3'h2:    res = CMD_PRECHARGE;
                3'h3:    res = CMD_ACTIVATE;
                3'h4:    res = CMD_WRITE;
                3'h5:    res = CMD_READ;
                default: res = CMD_NOP;
            endcase
        end
        return res;
    endfunction : decode_cmd

    // Lane enables from the data mask inputs
    function automatic logic [LANES-1:0] lane_en(input logic [`DDR2_DM_MAX-1:0] m);
        logic [LANES-1:0] res;
        res = '1;
        if (LANES == 2) begin
            res = LANES'(~m);
        end else begin
            res = LANES'(~m[0]);
        end
        return res;
    endfunction : lane_en

    // Synchroniser stages for every pin
    logic [SYNW-1:0] meta_q;
    logic [SYNW-1:0] sync_q;
    logic            ck_s;
    logic            ck_n_s;
    logic            cke_s;
    logic            cs_n_s;
    logic            ras_n_s;
    logic            cas_n_s;
    logic            we_n_s;
    logic [`DDR2_BANK_BITS-1:0] ba_s;
    logic [`DDR2_ADDR_BITS-1:0] addr_s;
    logic            odt_s;
    logic [DQ_WIDTH-1:0] dq_s;
    logic            dqs_s;
    logic [`DDR2_DM_MAX-1:0] dm_s;

    // Edge detection and core state
    logic            ck_p_q;
    logic            cke_p_q;
    logic            dqs_p_q;
    logic            ck_rise;
    logic            ck_fall;
    logic            dqs_edge;
    logic            cke_reg_q;
    logic            odt_reg_q;
    logic            rtt_on_q;
    pwr_state_t      state_q;
    logic [`DDR2_BANKS-1:0] open_q;
    cmd_t            cmd;
    logic            cmd_ok;

    // Burst bookkeeping
    logic [3:0]          wr_left_q;
    logic [ABITS-1:0]    wr_addr_q;
    logic [3:0]          rd_left_q;
    logic [ABITS-1:0]    rd_addr_q;
    logic                rd_pend_q;
    logic                rd_issue;
    logic                mem_wr;
    logic [DQ_WIDTH-1:0] mem_rd_data;
    logic                buf_in_ready;
    logic                buf_out_valid;
    logic                buf_pop;
    logic [DQ_WIDTH-1:0] buf_out_data;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt,
                       dq_i, dqs_i, dm_i};
            sync_q <= meta_q;
        end
    end

    assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s,
            odt_s, dq_s, dqs_s, dm_s} = sync_q;

    // Previous levels for edge finding
    always_ff @(posedge clk) begin
        if (srst) begin
            ck_p_q  <= 1'b0;
            cke_p_q <= 1'b0;
            dqs_p_q <= 1'b0;
        end else begin
            ck_p_q  <= ck_s;
            cke_p_q <= cke_s;
            dqs_p_q <= dqs_s;
        end
    end

    // The crossing is CK rising with CK# low; a self-refreshed part sees no clock
    assign ck_rise  = ck_s & ~ck_p_q & ~ck_n_s & (state_q != ST_SELF_REF);
    assign ck_fall  = ~ck_s & ck_p_q & (state_q == ST_ACTIVE);
    assign dqs_edge = (dqs_s ^ dqs_p_q) & (state_q == ST_ACTIVE);

    // Command only while CKE held high across the edge and CS# low
    assign cmd    = decode_cmd(cs_n_s, ras_n_s, cas_n_s, we_n_s);
    assign cmd_ok = ck_rise & cke_reg_q & cke_s & (state_q == ST_ACTIVE)
                  & ~cs_n_s;

    // CKE registered at the crossing; self refresh exit is taken without CK
    always_ff @(posedge clk) begin
        if (srst) begin
            cke_reg_q <= 1'b0;
        end else if (state_q == ST_SELF_REF) begin
            if (cke_s & ~cke_p_q) begin
                cke_reg_q <= 1'b1;
            end
        end else if (ck_rise) begin
            cke_reg_q <= cke_s;
        end
    end

    // Power state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_ACTIVE;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (ck_rise & cke_reg_q & ~cke_s) begin
                        if (~cs_n_s && cmd == CMD_REFRESH) begin
                            state_q <= ST_SELF_REF;
                        end else if (open_q == '0) begin
                            state_q <= ST_PD_PRE;
                        end else begin
                            state_q <= ST_PD_ACT;
                        end
                    end
                end
                ST_PD_PRE, ST_PD_ACT: begin
                    if (ck_rise & cke_s) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_SELF_REF: begin
                    if (cke_s & ~cke_p_q) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                default: state_q <= ST_ACTIVE;
            endcase
        end
    end

    // Internal clocking runs only when registered CKE is high and awake
    assign clocking_en = cke_reg_q & (state_q == ST_ACTIVE);
    assign pwr_state   = state_q;

    // Open-row tracking per bank
    always_ff @(posedge clk) begin
        if (srst) begin
            open_q <= '0;
        end else if (cmd_ok) begin
            if (cmd == CMD_ACTIVATE) begin
                open_q[ba_s] <= 1'b1;
            end else if (cmd == CMD_PRECHARGE) begin
                if (addr_s[`DDR2_A_ALL_BANKS]) begin
                    open_q <= '0;
                end else begin
                    open_q[ba_s] <= 1'b0;
                end
            end
        end
    end

    // Termination enable from mode load; a disabled setting masks ODT fully
    always_ff @(posedge clk) begin
        if (srst) begin
            rtt_on_q <= `DDR2_RTT_RESET;
        end else if (cmd_ok && cmd == CMD_LOAD_MODE && ba_s == `DDR2_EMR_BANK) begin
            rtt_on_q <= addr_s[`DDR2_EMR_RTT0] | addr_s[`DDR2_EMR_RTT1];
        end
    end

    // ODT is registered at each crossing, also during power-down
    always_ff @(posedge clk) begin
        if (srst) begin
            odt_reg_q <= 1'b0;
        end else if (state_q == ST_SELF_REF) begin
            odt_reg_q <= 1'b0;
        end else if (ck_rise) begin
            odt_reg_q <= odt_s;
        end
    end

    assign term_en    = odt_reg_q & rtt_on_q;
    // Only the configured data width gets termination; strobes and masks follow
    assign term_dq_en = {DQ_WIDTH{term_en}};

    // Write burst: one beat per strobe edge, each with its own mask
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_left_q <= 4'h0;
            wr_addr_q <= '0;
        end else if (cmd_ok && cmd == CMD_WRITE) begin
            wr_left_q <= BEATS;
            wr_addr_q <= {ba_s, addr_s[COL_BITS-1:0]};
        end else if (mem_wr) begin
            wr_left_q <= wr_left_q - 4'h1;
            wr_addr_q <= wr_addr_q + ABITS'(1);
        end
    end

    assign mem_wr = dqs_edge & (wr_left_q != 4'h0);

    // Read burst: fetch stalls whenever the output buffer is full
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_left_q <= 4'h0;
            rd_addr_q <= '0;
        end else if (cmd_ok && cmd == CMD_READ) begin
            rd_left_q <= BEATS;
            rd_addr_q <= {ba_s, addr_s[COL_BITS-1:0]};
        end else if (rd_issue) begin
            rd_left_q <= rd_left_q - 4'h1;
            rd_addr_q <= rd_addr_q + ABITS'(1);
        end
    end

    // One fetch in flight, so the buffer slot checked before it is still free
    assign rd_issue = (rd_left_q != 4'h0) & ~rd_pend_q & buf_in_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= rd_issue;
        end
    end

    word_mem #(
        .WIDTH      (DQ_WIDTH),
        .LANES      (LANES),
        .ABITS      (ABITS)
    ) u_mem (
        .clk        (clk),
        .wr_en      (mem_wr),
        .wr_addr    (wr_addr_q),
        .wr_data    (dq_s),
        .wr_lane_en (lane_en(dm_s)),
        .rd_en      (rd_issue),
        .rd_addr    (rd_addr_q),
        .rd_data    (mem_rd_data)
    );

    two_entry_buffer #(
        .WIDTH     (DQ_WIDTH)
    ) u_buf (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (rd_pend_q),
        .in_ready  (buf_in_ready),
        .in_data   (mem_rd_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .out_data  (buf_out_data)
    );

    // Beats leave on each CK crossing, so the drain stalls between edges
    assign buf_pop = (ck_rise | ck_fall) & (state_q == ST_ACTIVE);

    // Output driver: strobe copies CK so it is edge-aligned with the data
    always_ff @(posedge clk) begin
        if (srst) begin
            dq_o   <= '0;
            dq_oe  <= 1'b0;
            dqs_o  <= 1'b0;
            dqs_oe <= 1'b0;
        end else if (buf_pop) begin
            dq_oe  <= buf_out_valid;
            dqs_oe <= buf_out_valid;
            dqs_o  <= ck_s;
            if (buf_out_valid) begin
                dq_o <= buf_out_data;
            end
        end else if (state_q != ST_ACTIVE) begin
            dq_oe  <= 1'b0;                                                // Quiet when asleep
            dqs_oe <= 1'b0;
        end
    end
endmodule : ddr2_pin_core

// ===== tb/ddr2_pin_properties.sv
// Checker for the DDR2 pin core: output timing against CK and the power state.
// Assumes binding to ddr2_pin_core; pins reach the logic within 5 clk of a CK edge.
`timescale 1ns/100ps
module ddr2_pin_properties #(
    parameter int DQ_WIDTH = 16
) (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire logic                 ck,
    input wire logic                 cke,
    input wire logic                 dq_oe,
    input wire logic                 dqs_oe,
    input wire logic [DQ_WIDTH-1:0]  dq_o,
    input wire logic                 term_en,
    input wire logic [DQ_WIDTH-1:0]  term_dq_en,
    input wire logic                 clocking_en,
    input wire ddr2_pkg::pwr_state_t pwr_state
);
    import ddr2_pkg::*;
    logic       ck_q;
    logic [7:0] rise_q;
    logic [7:0] edge_q;
    // Previous CK level, to find its edges
    always_ff @(posedge clk) begin
        ck_q <= ck;
    end
    // Clocks since CK rose; saturates so a stopped CK never wraps
    always_ff @(posedge clk) begin
        if (srst) rise_q <= 8'hFF;
        else if (ck && !ck_q) rise_q <= 8'h00;
        else if (rise_q != 8'hFF) rise_q <= rise_q + 8'h01;
    end
    // Clocks since any CK crossing
    always_ff @(posedge clk) begin
        if (srst) edge_q <= 8'hFF;
        else if (ck != ck_q) edge_q <= 8'h00;
        else if (edge_q != 8'hFF) edge_q <= edge_q + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_term_lanes: assert property (term_dq_en == {DQ_WIDTH{term_en}})
        else $error("termination lanes differ from term_en");
    a_clock_gate: assert property (pwr_state != ST_ACTIVE |-> !clocking_en)
        else $error("clocking enabled outside active state");
    a_state_at_ck: assert property ($changed(pwr_state) && $past(pwr_state) != ST_SELF_REF
        |-> rise_q <= 8'h06) else $error("power state moved away from a CK rise");
    a_srx_exit: assert property (pwr_state == ST_SELF_REF && $rose(cke)
        |-> ##[1:6] pwr_state == ST_ACTIVE) else $error("self refresh exit missed");
    a_read_at_cross: assert property ($changed(dq_o) |-> edge_q <= 8'h06)
        else $error("read data moved away from a CK crossing");
    a_strobe_data: assert property (dq_oe |-> dqs_oe)
        else $error("read data driven without strobe");
    a_quiet_pd: assert property (pwr_state != ST_ACTIVE && $past(pwr_state) != ST_ACTIVE
        |-> !dq_oe) else $error("data driven in a low power state");
    a_odt_sref: assert property (pwr_state == ST_SELF_REF && $past(pwr_state) == ST_SELF_REF
        |-> $stable(term_en)) else $error("termination moved in self refresh");
    a_term_at_ck: assert property ($changed(term_en) |-> rise_q <= 8'h06)
        else $error("termination moved away from a CK rise");
    c_pd_act: cover property (pwr_state == ST_PD_ACT);
    c_pd_pre: cover property (pwr_state == ST_PD_PRE);
    c_sref: cover property (pwr_state == ST_SELF_REF);
    c_read: cover property ($rose(dq_oe));
endmodule : ddr2_pin_properties

bind ddr2_pin_core ddr2_pin_properties #(.DQ_WIDTH(DQ_WIDTH)) chk (.clk(clk), .srst(srst),
    .ck(ck), .cke(cke), .dq_oe(dq_oe), .dqs_oe(dqs_oe), .dq_o(dq_o), .term_en(term_en),
    .term_dq_en(term_dq_en), .clocking_en(clocking_en), .pwr_state(pwr_state));

// ===== tb/ddr2_ctl_model.sv
// Behavioural DDR2 controller: drives CK, command, address and write data pins.
// Assumes clk is the bench clock; CK stands still between commands.
`timescale 1ns/100ps
module ddr2_ctl_model (
    input  wire logic        clk,
    output logic             ck,
    output logic             ck_n,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [1:0]       ba,
    output logic [13:0]      addr,
    output logic             odt,
    output logic [15:0]      dq_i,
    output logic             dqs_i,
    output logic [1:0]       dm_i,
    input  wire logic [15:0] dq_o,
    input  wire logic        dq_oe
);
    logic [15:0] r_d;
    logic [15:0] f_d;
    logic        r_oe;
    logic        f_oe;
    // Power-up levels: clock enable low until the bench configures the part
    initial begin
        {ck, ck_n, cke, odt} = 4'h4;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {ba, addr} = 16'h0000;
        {dq_i, dqs_i, dm_i} = 19'h00000;
    end
    // One CK period of 16 clk, entered on a clk edge, so back-to-back calls give 64 ns;
    // pins settle 4 clk before the rise and hold through it
    task automatic cyc(input logic [3:0] cmd, input logic [1:0] b, input logic [13:0] a,
                       input logic k, input logic o);
        {cs_n, ras_n, cas_n, we_n} <= cmd;
        ba <= b;
        addr <= a;
        cke <= k;
        odt <= o;
        repeat (4) @(posedge clk);
        {ck, ck_n} <= 2'h2;
        repeat (6) @(posedge clk);
        {r_d, r_oe} = {dq_o, dq_oe};
        repeat (2) @(posedge clk);
        {ck, ck_n} <= 2'h1;
        repeat (4) @(posedge clk);
        {f_d, f_oe} = {dq_o, dq_oe};
    endtask : cyc
    // Write beats: DQS toggles mid-beat, so data and mask frame each edge
    task automatic wburst(input logic [63:0] d, input logic [7:0] m);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dq_i <= d[16*i +: 16];
            dm_i <= m[2*i +: 2];
            repeat (4) @(posedge clk);
            dqs_i <= ~dqs_i;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        dq_i <= ~d[63:48];
        dm_i <= ~m[7:6];
    endtask : wburst
    // Clock enable change with CK stopped
    task automatic cke_async(input logic k);
        @(posedge clk);
        cke <= k;
        repeat (8) @(posedge clk);
    endtask : cke_async
endmodule : ddr2_ctl_model

// ===== tb/tb_top.sv
// Bench for the DDR2 pin core: mode load, masked writes, reads, power modes.
// Assumes ddr2_ctl_model drives the pins and the checker is bound to the core.
`timescale 1ns/100ps
module tb_top;
    import ddr2_pkg::*;
    logic clk, srst, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_i, dq_oe;
    logic dqs_o, dqs_oe, term_en, clocking_en;
    logic [1:0]  ba, dm_i, b;
    logic [13:0] addr;
    logic [15:0] dq_i, dq_o, term_dq_en;
    logic [3:0]  c;
    logic [31:0] r;
    logic [63:0] d;
    logic [15:0] ref_mem [64];
    pwr_state_t  pwr_state;
    int          num_errors, n_tests, seed;
    ddr2_pin_core #(.DQ_WIDTH(16)) u_ddr2_pin_core (.clk(clk), .srst(srst), .ck(ck),
        .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .odt(odt), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .dm_i(dm_i), .term_en(term_en),
        .term_dq_en(term_dq_en), .clocking_en(clocking_en), .pwr_state(pwr_state));
    ddr2_ctl_model ctl (.clk(clk), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
        .dq_i(dq_i), .dqs_i(dqs_i), .dm_i(dm_i), .dq_o(dq_o), .dq_oe(dq_oe));
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_state(input pwr_state_t got, input pwr_state_t exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_state
    task automatic summarize;
        $display("tests=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // Byte lanes with the mask set keep the old word
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                          input logic [1:0] m);
        return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
    endfunction : merge
    // Write burst and reference update
    task automatic wr(input logic [63:0] wd, input logic [7:0] m);
        logic [5:0] a;
        ctl.cyc(4'h4, b, {10'h000, c}, 1'b1, 1'b0);
        ctl.wburst(wd, m);
        for (int i = 0; i < 4; i++) begin
            a = {b, c} + i[5:0];
            ref_mem[a] = merge(ref_mem[a], wd[16*i +: 16], m[2*i +: 2]);
        end
    endtask : wr
    // Read burst: beats at the fall of the READ period, then rise, fall, rise
    task automatic rd_check;
        logic [5:0] a;
        a = {b, c};
        ctl.cyc(4'h5, b, {10'h000, c}, 1'b1, 1'b0);
        chk_val(ctl.f_d, ref_mem[a]);
        chk_val({14'h0000, dqs_oe, dqs_o}, 16'h0002);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        chk_val(ctl.r_d, ref_mem[a + 6'h01]);
        chk_val(ctl.f_d, ref_mem[a + 6'h02]);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        chk_val(ctl.r_d, ref_mem[a + 6'h03]);
        chk_val({14'h0000, dqs_oe, ctl.f_oe}, 16'h0000);
    endtask : rd_check
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Watchdog well beyond the expected 1261 clk of traffic
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end
    initial begin
        {srst, seed, num_errors, n_tests} = {1'b1, 32'd67, 32'd0, 32'd0};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        chk_state(pwr_state, ST_ACTIVE);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        chk_val({15'h0000, clocking_en}, 16'h0001);
        // Extended mode load turns termination on, then ODT drives it
        ctl.cyc(4'h0, 2'h1, 14'h0004, 1'b1, 1'b0);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b1);
        chk_val(term_dq_en, 16'hFFFF);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        chk_val({15'h0000, term_en}, 16'h0000);
        // Full write, masked overwrite, deselected read, then read back
        for (int n = 0; n < 6; n++) begin
            r = $random(seed);
            {b, c} = {r[1:0], r[3:2], 2'h0};
            d = {$random(seed), $random(seed)};
            wr(d, 8'h00);
            r = $random(seed);
            wr(~d, (n == 0) ? 8'hFF : (n == 1) ? 8'h99 : r[7:0]);
            ctl.cyc(4'hD, b, {10'h000, c}, 1'b1, 1'b0);
            chk_val({15'h0000, ctl.f_oe}, 16'h0000);
            rd_check();
        end
        // Open row, then clock enable low: active power-down, ODT still heard
        ctl.cyc(4'h3, 2'h2, 14'h0010, 1'b1, 1'b0);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b0, 1'b1);
        chk_state(pwr_state, ST_PD_ACT);
        chk_val({15'h0000, clocking_en}, 16'h0000);
        chk_val({15'h0000, term_en}, 16'h0001);
        ctl.cyc(4'h5, 2'h2, 14'h0000, 1'b0, 1'b0);
        chk_val({15'h0000, ctl.f_oe}, 16'h0000);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        chk_state(pwr_state, ST_ACTIVE);
        ctl.cyc(4'h2, 2'h0, 14'h0400, 1'b1, 1'b0);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b0, 1'b0);
        chk_state(pwr_state, ST_PD_PRE);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b0);
        // Refresh with clock enable falling enters self refresh
        ctl.cyc(4'h1, 2'h0, 14'h0000, 1'b0, 1'b0);
        chk_state(pwr_state, ST_SELF_REF);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b0, 1'b1);
        chk_val({15'h0000, term_en}, 16'h0000);
        ctl.cke_async(1'b1);
        chk_state(pwr_state, ST_ACTIVE);
        // Termination off by mode load: ODT no longer heard
        ctl.cyc(4'h0, 2'h1, 14'h0000, 1'b1, 1'b0);
        ctl.cyc(4'h7, 2'h0, 14'h0000, 1'b1, 1'b1);
        chk_val({15'h0000, term_en}, 16'h0000);
        summarize();
    end
endmodule : tb_top
